// ### core/rie_irq_core.sv
`timescale 1ns/1ps
module rie_irq_core import rie_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // axi4-lite write address
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // request flags and transceiver state
    input wire rie_evt_s evtFlags,
    input wire rie_ctl_s ctl,
    input wire rie_fifo_s fifoIn,
    // results
    output logic combinedRequest,
    output logic errorEvent,
    output logic fifoWriteAccept,
    // interrupt pin, two signals
    output logic irqPinOut,
    output logic irqPinOe,
    // software interrupt
    output logic irqOut
);
    function automatic rie_reg_e decode(input logic [11:0] addr);
        rie_reg_e r;
        r = REG_NONE;
        if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
            unique case (addr[9:2])
                READER_EN_IDX: r = REG_READER_EN;
                TIMER_EN_IDX: r = REG_TIMER_EN;
                ERR_IDX: r = REG_ERR;
                IRQ_STAT_IDX: r = REG_STAT;
                IRQ_MASK_IDX: r = REG_MASK;
                STATE_IDX: r = REG_STATE;
                default: r = REG_NONE;
            endcase
        end
        return r;
    endfunction

    logic [7:0] readerEn_q;
    logic [7:0] timerEn_q;
    logic [3:0] irqMask_q;
    logic [3:0] irqStat_q;
    logic nvmFault_q;
    logic wrErr_q;
    logic ovl_q;
    logic wrErrPending_q;
    logic [11:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic combReq_q;
    logic errEvt_q;
    logic accept_q;
    logic pinOut_q;
    logic pinOe_q;
    logic irqOut_q;

    logic doWrite;
    rie_reg_e wrReg;
    logic wrLane0;
    logic [7:0] wrByte;
    logic [6:0] readerHit;
    logic [5:0] timerHit;
    logic combReq_d;
    logic errEvt_d;
    logic misplaced;
    logic [3:0] events;
    logic reqSeen_q;
    logic pinLevel;
    logic [7:0] errReg;
    logic [2:0] stateWord;
    logic fullWrite;
    logic wrReaderEn;
    logic wrTimerEn;
    logic wrMask;
    logic wrStat;

    assign doWrite = !awready_q && !wready_q && !bvalid_q;
    assign wrReg = decode(awAddr_q);
    assign wrLane0 = wStrb_q[0];
    assign wrByte = wData_q[7:0];
    assign errReg = {nvmFault_q, wrErr_q, ovl_q, ctl.rxErrors};
    assign stateWord = {errEvt_q, pinLevel, combReq_q};
    assign fullWrite = fifoIn.wrStrobe && fifoIn.full;

    // write strobes; lane 0 off still answers but leaves the register alone
    assign wrReaderEn = doWrite && wrLane0 && (wrReg == REG_READER_EN);
    assign wrTimerEn = doWrite && wrLane0 && (wrReg == REG_TIMER_EN);
    assign wrMask = doWrite && wrLane0 && (wrReg == REG_MASK);
    assign wrStat = doWrite && wrLane0 && (wrReg == REG_STAT);

    // gating of individual flags into the combined request
    assign readerHit = evtFlags.readerFlags & readerEn_q[6:0]; // [RULE_02]
    assign timerHit[5] = evtFlags.timerFlags[5] & timerEn_q[5]; // [RULE_05]
    assign timerHit[4:0] = evtFlags.timerFlags[4:0] & timerEn_q[4:0]; // [RULE_06]
    assign combReq_d = |readerHit || |timerHit; // [RULE_13]

    // error event: write error, overflow, protocol, no data, integrity
    assign errEvt_d = wrErr_q || ovl_q || ctl.rxErrors[1] || ctl.rxErrors[3]
        || ctl.rxErrors[0]; // [RULE_14]

    assign misplaced = fifoIn.wrStrobe && (ctl.crcTrailing || ctl.authActive
        || ctl.comState == CS_RXWAIT || ctl.comState == CS_WAITDATA
        || ctl.comState == CS_RECEIVING); // [RULE_08]

    // polarity applied last, so a gated-off pin sits at its idle level
    assign pinLevel = (combReq_q && timerEn_q[PIN_GATE_BIT])
        ^ readerEn_q[INV_BIT]; // [RULE_04] [RULE_01] [RULE_15]

    // axi write channels; address and data taken in either order
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awAddr_q <= 12'h000;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else begin
            if (awvalid && awready_q) begin
                awAddr_q <= awaddr;
                awready_q <= 1'b0;
            end
            if (wvalid && wready_q) begin
                wData_q <= wdata;
                wStrb_q <= wstrb;
                wready_q <= 1'b0;
            end
            if (doWrite) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wrReg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // axi read channel, answer one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            unique case (decode(araddr))
                REG_READER_EN: rdata_q <= {24'h000000, readerEn_q};
                REG_TIMER_EN: rdata_q <= {24'h000000, timerEn_q};
                REG_ERR: rdata_q <= {24'h000000, errReg};
                REG_STAT: rdata_q <= {28'h0000000, irqStat_q};
                REG_MASK: rdata_q <= {28'h0000000, irqMask_q};
                // state bits are live copies, not sticky
                REG_STATE: rdata_q <= {29'h0, stateWord};
                REG_NONE: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // enable and mask registers written by software
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            readerEn_q <= EN_RESET;
            timerEn_q <= EN_RESET;
            irqMask_q <= MASK_RESET;
        end else begin
            if (wrReaderEn) begin
                readerEn_q <= wrByte;
            end
            if (wrTimerEn) begin
                timerEn_q <= wrByte;
            end
            if (wrMask) begin
                irqMask_q <= wrByte[3:0];
            end
        end
    end

    // fault of the most recent nvm command
    // a fault in the same cycle as a new start is kept
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            nvmFault_q <= 1'b0;
        end else if (ctl.nvmCmdFault) begin
            nvmFault_q <= 1'b1; // [RULE_07]
        end else if (ctl.nvmCmdStart) begin
            nvmFault_q <= 1'b0;
        end
    end

    // misplaced write flag; a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrErr_q <= 1'b0;
            wrErrPending_q <= 1'b0;
        end else if (misplaced) begin
            wrErr_q <= 1'b1; // [RULE_08]
            wrErrPending_q <= 1'b0;
        end else if (ctl.cmdStart && !ctl.multiFrameReceive) begin
            wrErr_q <= 1'b0; // [RULE_09]
            wrErrPending_q <= 1'b0;
        end else if (ctl.cmdStart) begin
            // the flag must still reach the buffer with the other errors
            wrErrPending_q <= 1'b1; // [RULE_10]
        end else if (wrErrPending_q && ctl.errFlagsStored) begin
            wrErr_q <= 1'b0; // [RULE_10]
            wrErrPending_q <= 1'b0;
        end else if (!ctl.multiFrameReceive && wrErrPending_q) begin
            wrErr_q <= 1'b0; // [RULE_09]
            wrErrPending_q <= 1'b0;
        end
    end

    // overflow flag and write discard
    // only a new command clears overflow, software cannot
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ovl_q <= 1'b0;
            accept_q <= 1'b0;
        end else begin
            accept_q <= fifoIn.wrStrobe && !fifoIn.full && !ovl_q; // [RULE_12]
            if (fullWrite) begin
                ovl_q <= 1'b1; // [RULE_11]
            end else if (ctl.cmdStart) begin
                ovl_q <= 1'b0;
            end
        end
    end

    // combined request, and its last value for the rise detector
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            combReq_q <= 1'b0;
            reqSeen_q <= 1'b0;
        end else begin
            combReq_q <= combReq_d; // [RULE_13]
            reqSeen_q <= combReq_q;
        end
    end

    // error event
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            errEvt_q <= 1'b0;
        end else begin
            errEvt_q <= errEvt_d; // [RULE_14]
        end
    end

    // interrupt pin drive: push-pull drives both levels, open drain only low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinOut_q <= 1'b0;
            pinOe_q <= 1'b0;
        end else if (timerEn_q[DRIVE_BIT]) begin
            pinOut_q <= pinLevel; // [RULE_03]
            pinOe_q <= 1'b1;
        end else begin
            pinOut_q <= 1'b0; // [RULE_03]
            pinOe_q <= !pinLevel;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    // a flag already set gives no new event, so repeats are not counted
    assign events[ST_NVM] = ctl.nvmCmdFault && !nvmFault_q;
    assign events[ST_WRERR] = misplaced && !wrErr_q;
    assign events[ST_OVL] = fullWrite && !ovl_q;
    assign events[ST_REQ] = combReq_q && !reqSeen_q;

    generate
        for (genvar i = 0; i < 4; i++) begin : g_stat
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    irqStat_q[i] <= 1'b0;
                end else if (events[i]) begin
                    irqStat_q[i] <= 1'b1;
                end else if (wrStat && wrByte[i]) begin
                    irqStat_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqOut_q <= 1'b0;
        end else begin
            irqOut_q <= |(irqStat_q & irqMask_q);
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign combinedRequest = combReq_q;
    assign errorEvent = errEvt_q;
    assign fifoWriteAccept = accept_q;
    assign irqPinOut = pinOut_q;
    assign irqPinOe = pinOe_q;
    assign irqOut = irqOut_q;
endmodule

// ### common/rie_pkg.sv
// What this block does
// [RULE_01] pin polarity invert bit flips interrupt pin
// [RULE_02] reader event gates feed combined request
// [RULE_03] drive select: push-pull or open drain
// [RULE_04] pin output gate passes combined request
// [RULE_05] card detect gate feeds combined request
// [RULE_06] timer gates feed combined request
// [RULE_07] nvm command fault flag on error
// [RULE_08] misplaced buffer write sets flag
// [RULE_09] new command clears misplaced write flag
// [RULE_10] multi-frame: clear after error flags stored
// [RULE_11] write to full buffer sets overflow
// [RULE_12] after overflow every buffer write discarded
// [RULE_13] combined request from any gated flag
// [RULE_14] error event from five error flags
// [RULE_15] pin disabled holds inactive level
package rie_pkg;
    // register indices, byte address is index times four
    localparam logic [7:0] READER_EN_IDX = 8'h08;
    localparam logic [7:0] TIMER_EN_IDX = 8'h09;
    localparam logic [7:0] ERR_IDX = 8'h0A;
    localparam logic [7:0] IRQ_STAT_IDX = 8'h20;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
    localparam logic [7:0] STATE_IDX = 8'h22;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // enable bit positions
    localparam int INV_BIT = 7;
    localparam int DRIVE_BIT = 7;
    localparam int PIN_GATE_BIT = 6;
    // error register bit positions
    localparam int NVM_BIT = 7;
    localparam int WRERR_BIT = 6;
    localparam int OVL_BIT = 5;
    // interrupt status bit positions
    localparam int ST_NVM = 0;
    localparam int ST_WRERR = 1;
    localparam int ST_OVL = 2;
    localparam int ST_REQ = 3;
    // transceiver states where a buffer write is misplaced
    localparam logic [2:0] CS_RXWAIT = 3'h5;
    localparam logic [2:0] CS_WAITDATA = 3'h6;
    localparam logic [2:0] CS_RECEIVING = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        REG_READER_EN, REG_TIMER_EN, REG_ERR,
        REG_STAT, REG_MASK, REG_STATE, REG_NONE
    } rie_reg_e;

    typedef struct packed {
        logic [6:0] readerFlags;
        logic [5:0] timerFlags;
    } rie_evt_s;

    typedef struct packed {
        logic cmdStart;
        logic multiFrameReceive;
        logic errFlagsStored;
        logic crcTrailing;
        logic authActive;
        logic [2:0] comState;
        logic nvmCmdStart;
        logic nvmCmdFault;
        logic [4:0] rxErrors;
    } rie_ctl_s;

    typedef struct packed {
        logic wrStrobe;
        logic full;
    } rie_fifo_s;
endpackage

// ### sim/rie_irq_props.sv
`timescale 1ns/1ps
module rie_irq_props import rie_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register bus
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // events and results
    input wire rie_evt_s evtFlags,
    input wire rie_ctl_s ctl,
    input wire rie_fifo_s fifoIn,
    input wire logic combinedRequest,
    input wire logic errorEvent,
    input wire logic fifoWriteAccept,
    input wire logic irqPinOut,
    input wire logic irqPinOe
);
    logic [11:0] adr_q;
    logic [7:0] dat_q, rdEn_q, tmEn_q;
    logic [1:0] quiet_q;
    logic cr_q, anyEn, lvl;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // shadow enables lag the real ones, so gate checks wait for a quiet bus
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdEn_q <= 8'h00;
            tmEn_q <= 8'h00;
        end else if (bvalid && bready && bresp == RESP_OKAY) begin
            if (adr_q == 12'h020) rdEn_q <= dat_q;
            if (adr_q == 12'h024) tmEn_q <= dat_q;
        end
    end
    always_ff @(posedge clk) begin
        if (awvalid && awready) adr_q <= awaddr;
        if (wvalid && wready) dat_q <= wdata[7:0];
        cr_q <= combinedRequest;
    end
    always_ff @(posedge clk) begin
        if (!rst_b || awvalid || wvalid || bvalid) quiet_q <= 2'h0;
        else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
    end
    assign anyEn = |({rdEn_q[6:0], tmEn_q[5:0]} & evtFlags);
    assign lvl = (cr_q & tmEn_q[PIN_GATE_BIT]) ^ rdEn_q[INV_BIT];
    sequence s_full_write;
        fifoIn.wrStrobe && fifoIn.full && !ctl.cmdStart;
    endsequence
    sequence s_late_write;
        fifoIn.wrStrobe && !ctl.cmdStart;
    endsequence
    property p_ovl_discard;
        s_full_write ##1 s_late_write |=> !fifoWriteAccept;
    endproperty
    property p_accept_cause;
        fifoWriteAccept |-> $past(fifoIn.wrStrobe && !fifoIn.full);
    endproperty
    property p_ovl_err;
        s_full_write |-> ##[1:2] errorEvent;
    endproperty
    property p_misplaced;
        fifoIn.wrStrobe && (ctl.crcTrailing || ctl.authActive || ctl.comState >= CS_RXWAIT)
            |-> ##[1:2] errorEvent;
    endproperty
    property p_rx_err;
        |{ctl.rxErrors[3], ctl.rxErrors[1:0]} |=> errorEvent;
    endproperty
    property p_od;
        !irqPinOe |-> !irqPinOut;
    endproperty
    property p_request;
        quiet_q == 2'h3 |-> combinedRequest == $past(anyEn);
    endproperty
    property p_pin;
        quiet_q == 2'h3 |-> irqPinOe == (tmEn_q[DRIVE_BIT] || !lvl)
            && irqPinOut == (tmEn_q[DRIVE_BIT] && lvl);
    endproperty
    a_ovl_discard: assert property (p_ovl_discard)
        else $error("write taken after overflow");
    a_accept_cause: assert property (p_accept_cause)
        else $error("stray write accept");
    a_ovl_err: assert property (p_ovl_err) else $error("overflow not flagged");
    a_misplaced: assert property (p_misplaced) else $error("misplaced write missed");
    a_rx_err: assert property (p_rx_err) else $error("error event missing");
    a_od: assert property (p_od) else $error("open drain drove high");
    a_request: assert property (p_request) else $error("combined request wrong");
    a_pin: assert property (p_pin) else $error("pin drive wrong");
endmodule
bind rie_irq_core rie_irq_props u_props (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .evtFlags(evtFlags), .ctl(ctl),
    .fifoIn(fifoIn), .combinedRequest(combinedRequest), .errorEvent(errorEvent),
    .fifoWriteAccept(fifoWriteAccept), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe));

// ### sim/rie_host_pin_model.sv
`timescale 1ns/1ps
module rie_host_pin_model (
    // pin drive from the block
    input wire logic irqPinOut,
    input wire logic irqPinOe,
    // level seen by the host
    output logic pinWire
);
    // host pull-up lifts a released open-drain line
    assign pinWire = irqPinOe ? irqPinOut : 1'b1;
endmodule

// ### sim/reader_irq_enable_and_error_flags_tb_top.sv
`timescale 1ns/1ps
module reader_irq_enable_and_error_flags_tb_top import rie_pkg::*; ;
    logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, combinedRequest, errorEvent;
    logic fifoWriteAccept, irqPinOut, irqPinOe, irqOut, pinWire, cr, lv;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, r;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [12:0] oh;
    rie_evt_s evtFlags;
    rie_ctl_s ctl;
    rie_fifo_s fifoIn;
    logic [33:0] expQ[$];
    int n_fail, total_checks;
    localparam logic [14:0] CMD = 15'h4000, MULTI = 15'h2000, STORED = 15'h1000;
    localparam logic [14:0] NVMS = 15'h0040, NVMF = 15'h0020;
    localparam logic [14:0] CAUSE[5] = '{15'h0280, 15'h0300, 15'h0380, 15'h0800, 15'h0400};
    localparam logic [11:0] ADRS[5] = '{12'h020, 12'h024, 12'h028, 12'h080, 12'h084};
    rie_irq_core dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .evtFlags(evtFlags), .ctl(ctl), .fifoIn(fifoIn), .combinedRequest(combinedRequest),
        .errorEvent(errorEvent), .fifoWriteAccept(fifoWriteAccept), .irqPinOut(irqPinOut),
        .irqPinOe(irqPinOe), .irqOut(irqOut));
    rie_host_pin_model host (.irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .pinWire(pinWire));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic b;
        b = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!b) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) b = 1'b1;
            if (b) chk("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic done;
        done = 1'b0;
        expQ.push_back({er, e});
        araddr <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            done = rvalid && rready;
        end
    endtask
    // levels stay applied after the pulse clears
    task automatic ctlp(input logic [14:0] l, input logic [14:0] p);
        ctl <= rie_ctl_s'(l | p);
        tick(1);
        ctl <= rie_ctl_s'(l);
    endtask
    task automatic fw(input logic acc);
        fifoIn <= rie_fifo_s'(2'b10);
        tick(1);
        fifoIn <= rie_fifo_s'(2'b00);
        tick(1);
        chk("accept", {31'h0, fifoWriteAccept}, {31'h0, acc});
    endtask
    always @(posedge clk) begin
        if (rst_b && rvalid && rready && expQ.size() > 0) begin
            chk("rdata", rdata, expQ[0][31:0]);
            chk("rresp", {30'h0, rresp}, {30'h0, expQ[0][33:32]});
            void'(expQ.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        {bready, rready, wstrb, rst_b} = 7'h7E;
        evtFlags = '0;
        ctl = '0;
        fifoIn = '0;
        seed = 32'd56484;
        tick(10);
        rst_b <= 1'b1;
        tick(1);
        for (int k = 0; k < 5; k++) rd(ADRS[k], 32'h0, RESP_OKAY);
        rd(12'h100, 32'h0, RESP_SLVERR);
        rd(12'h022, 32'h0, RESP_SLVERR);
        wr(12'h028, 8'hFF);
        rd(12'h028, 32'h0, RESP_OKAY);
        for (int i = 0; i < 26; i++) begin
            r = xs();
            oh = 13'h1 << (i % 13);
            evtFlags <= rie_evt_s'(r[12:0]);
            wr(12'h020, {r[13], oh[12:6]});
            wr(12'h024, {r[14], r[15], oh[5:0]});
            tick(2);
            cr = |(oh & r[12:0]);
            lv = (cr & r[15]) ^ r[13];
            chk("pin", {31'h0, pinWire}, {31'h0, lv});
            rd(12'h024, {24'h0, r[14], r[15], oh[5:0]}, RESP_OKAY);
            rd(12'h088, {30'h0, lv, cr}, RESP_OKAY);
        end
        evtFlags <= '0;
        wr(12'h020, 8'h00);
        wr(12'h024, 8'h00);
        wr(12'h080, 8'h0F);
        ctlp(15'h0, NVMF);
        tick(2);
        chk("irq", {31'h0, irqOut}, 32'h0);
        rd(12'h080, 32'h1, RESP_OKAY);
        rd(12'h028, 32'h80, RESP_OKAY);
        wr(12'h084, 8'h01);
        tick(2);
        chk("irq", {31'h0, irqOut}, 32'h1);
        wr(12'h080, 8'h01);
        tick(2);
        chk("irq", {31'h0, irqOut}, 32'h0);
        ctlp(15'h0, NVMS);
        rd(12'h028, 32'h0, RESP_OKAY);
        for (int k = 0; k < 5; k++) begin
            ctlp(CAUSE[k], 15'h0);
            fw(1'b1);
            rd(12'h028, 32'h40, RESP_OKAY);
            rd(12'h088, 32'h4, RESP_OKAY);
            ctlp(15'h0, CMD);
            tick(1);
            rd(12'h028, 32'h0, RESP_OKAY);
        end
        ctlp(CAUSE[0], 15'h0);
        fw(1'b1);
        ctlp(MULTI, CMD);
        tick(1);
        rd(12'h028, 32'h40, RESP_OKAY);
        ctlp(MULTI, STORED);
        tick(1);
        rd(12'h028, 32'h0, RESP_OKAY);
        ctlp(15'h0, 15'h0);
        // two back-to-back writes: the first overflows, the second must be dropped
        fifoIn <= rie_fifo_s'(2'b11);
        tick(1);
        fifoIn <= rie_fifo_s'(2'b10);
        tick(1);
        fifoIn <= rie_fifo_s'(2'b00);
        tick(1);
        chk("accept", {31'h0, fifoWriteAccept}, 32'h0);
        fw(1'b0);
        rd(12'h028, 32'h20, RESP_OKAY);
        rd(12'h080, 32'h6, RESP_OKAY);
        wr(12'h084, 8'h04);
        tick(2);
        chk("irq", {31'h0, irqOut}, 32'h1);
        wr(12'h084, 8'h00);
        tick(2);
        chk("irq", {31'h0, irqOut}, 32'h0);
        ctlp(15'h0, CMD);
        fw(1'b1);
        r = xs();
        ctlp({10'h0, r[4:1], 1'b1}, 15'h0);
        tick(2);
        rd(12'h028, {27'h0, r[4:1], 1'b1}, RESP_OKAY);
        rd(12'h088, 32'h4, RESP_OKAY);
        // a rise of the combined request is latched in status bit 3
        wr(12'h080, 8'h0F);
        evtFlags <= rie_evt_s'(13'h0040);
        wr(12'h020, 8'h01);
        wr(12'h084, 8'h08);
        tick(2);
        chk("irq", {31'h0, irqOut}, 32'h1);
        rd(12'h080, 32'h8, RESP_OKAY);
        rd(12'h088, 32'h5, RESP_OKAY);
        tally_and_finish();
    end
endmodule
